// *** hw/lcd_ctl_defines.vh ***
/*
 * constants for the character display instruction decoder: rates,
 * row bases, timing counts at the internal oscillator rate.
 * assumes a 20 mhz system clock and an oscillator enable derived from it.
 */
`ifndef LCD_CTL_DEFINES_VH
`define LCD_CTL_DEFINES_VH

// system and oscillator rates
`define CLK_HZ          20000000
`define OSC_HZ          270000
// system cycles per oscillator tick, rounded down
`define OSC_DIV         (`CLK_HZ / `OSC_HZ)

// execution times as printed
`define T_LONG_NS       1520000
`define T_SHORT_NS      38000
// oscillator ticks, least time rounded up
`define T_LONG_TICKS    ((`T_LONG_NS * (`OSC_HZ / 1000) + 999999) / 1000000)
`define T_SHORT_TICKS   ((`T_SHORT_NS * (`OSC_HZ / 1000) + 999999) / 1000000)

// display ram row bases
`define ROW1_BASE       7'h00
`define ROW3_BASE       7'h14
`define ROW2_BASE       7'h40
`define ROW4_BASE       7'h54
`define LINE1_LAST      7'h27
`define LINE2_LAST      7'h67
`define ONE_LINE_LAST   7'h4f

// fill code for clear, all-ones code for the blink cell
`define SPACE_CODE      8'h20
`define ONES_CODE       8'hff

// reset values of configuration
`define RST_BUS_WIDTH   1'b1
`define RST_LINES       1'b1

// display and glyph ram depths
`define DISP_DEPTH      80
`define GLYPH_DEPTH     64

`endif

// *** hw/osc_tick.v ***
/*
 * oscillator tick divider: one-cycle enable at about 270 khz.
 * assumes the system clock given in the defines header.
 */
`timescale 1ns/1ps
`include "lcd_ctl_defines.vh"

module osc_tick (
  input  wire clock,
  input  wire nrst,
  output reg  tick
);

  reg [6:0] count;  // cycles since last tick

  localparam [31:0] DIV_LAST = `OSC_DIV - 1;  // last count before the wrap

  // free-running divider, tick on wrap
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count == DIV_LAST[6:0]) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end

endmodule // osc_tick

// *** hw/read_buf.v ***
/*
 * two-entry buffer on the read data path so a stalled reader keeps two words behind the output stage.
 * assumes both sides on the same clock.
 */
`timescale 1ns/1ps

module read_buf (
  input  wire       clock,
  input  wire       nrst,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output wire [7:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);

  reg [7:0] mem [0:1];  // two words
  reg       wr_ptr;     // write slot
  reg       rd_ptr;     // read slot
  reg [1:0] fill;       // words held

  assign in_ready  = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);
  assign out_data  = mem[rd_ptr];

  // push and pop, fill tracks both
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'd0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (in_valid && in_ready) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (out_valid && out_ready)
        rd_ptr <= ~rd_ptr;
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10:   fill <= fill + 2'd1;
        2'b01:   fill <= fill - 2'd1;
        default: fill <= fill;
      endcase
    end
  end

endmodule // read_buf

// *** hw/lcd_ctl.v ***
/*
 * instruction decoder and address counter of a 20x4 character display
 * controller: parallel bus with select, read/write and enable, display and
 * glyph rams, busy timing at the internal oscillator rate.
 * assumes bus pins are asynchronous and the host polls busy before writing.
 */
`timescale 1ns/1ps
`include "lcd_ctl_defines.vh"

module lcd_ctl (
  input  wire       clock,
  input  wire       nrst,
  input  wire       reg_select,     // high selects data
  input  wire       read_write,     // high reads
  input  wire       enable,         // bus strobe
  input  wire [7:0] bus_in,         // data pins in
  output reg  [7:0] bus_out,        // data pins out
  output reg        bus_oe,         // high while driving pins
  output reg        busy_flag,
  output reg  [6:0] addr_counter,
  output reg        display_on,
  output reg        cursor_on,
  output reg        blink_on,
  output reg        bus_width,
  output reg        two_line,
  output reg        font_tall,
  output reg  [6:0] shift_offset,   // display origin
  output reg        blink_phase,    // cursor cell shown as ones
  output reg  [7:0] cursor_cell,    // character at cursor as seen
  input  wire       rd_ready,       // reader accepts read data
  output reg  [7:0] rd_data,
  output reg        rd_valid
);

  reg [7:0] disp_mem [0:`DISP_DEPTH-1];   // display ram
  reg [7:0] glyph_mem [0:`GLYPH_DEPTH-1]; // glyph ram

  // bus synchronisers, first stage read only by second
  reg [10:0] sync1;
  reg [10:0] sync2;
  reg        en_last;       // for falling edge

  wire       s_rs  = sync2[10];
  wire       s_rw  = sync2[9];
  wire       s_en  = sync2[8];
  wire [7:0] s_dat = sync2[7:0];

  reg        dir_inc;       // entry direction
  reg        auto_scroll;
  reg        sel_glyph;     // glyph ram selected
  reg        nib_hi_done;   // first nibble held
  reg  [3:0] nib_hold;
  reg [12:0] busy_count;    // oscillator ticks left
  reg  [6:0] clr_idx;       // clear sweep position
  reg        clearing;
  reg  [8:0] blink_div;     // ticks per blink phase

  wire       tick;
  wire       buf_in_ready;
  wire [7:0] buf_out_data;
  wire       buf_out_valid;
  reg        buf_push;
  reg  [7:0] buf_word;
  wire       buf_pop = rd_ready || !rd_valid;  // output stage empty or being taken

  // counts sized once, then cut to the counter width on purpose
  localparam [31:0] SHORT_T = `T_SHORT_TICKS;
  localparam [31:0] LONG_T  = `T_LONG_TICKS;
  localparam [31:0] CLR_END = `DISP_DEPTH - 1;

  osc_tick osc_tick_i (
    .clock (clock),
    .nrst  (nrst),
    .tick  (tick)
  );

  read_buf read_buf_i (
    .clock     (clock),
    .nrst      (nrst),
    .in_data   (buf_word),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop)
  );

  // step a display address with the line wrap of the active mode
  function [6:0] step_disp;
    input [6:0] a;
    input       inc;
    input       two;
    begin
      if (inc) begin
        if (!two)
          step_disp = (a >= `ONE_LINE_LAST) ? `ROW1_BASE : a + 7'h01;
        else if (a == `LINE1_LAST)
          step_disp = `ROW2_BASE;
        else if (a >= `LINE2_LAST)
          step_disp = `ROW1_BASE;
        else
          step_disp = a + 7'h01;
      end else begin
        if (!two)
          step_disp = (a == 7'h00) ? `ONE_LINE_LAST : a - 7'h01;
        else if (a == `ROW2_BASE)
          step_disp = `LINE1_LAST;
        else if (a == 7'h00)
          step_disp = `LINE2_LAST;
        else
          step_disp = a - 7'h01;
      end
    end
  endfunction

  // step the counter in whichever ram is selected
  function [6:0] step_addr;
    input [6:0] a;
    input       inc;
    input       two;
    input       glyph;
    begin
      if (glyph)
        step_addr = {1'b0, inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      else
        step_addr = step_disp(a, inc, two);
    end
  endfunction

  // row address to linear storage index
  function [6:0] disp_index;
    input [6:0] a;
    begin
      disp_index = a[6] ? (a - `ROW2_BASE + 7'd40) : a;
    end
  endfunction

  // shift origin stays in 0..39 per line
  function [6:0] wrap40;
    input [6:0] o;
    input       right;
    begin
      if (right)
        wrap40 = (o == 7'd0) ? 7'd39 : o - 7'd1;
      else
        wrap40 = (o == 7'd39) ? 7'd0 : o + 7'd1;
    end
  endfunction

  // pins through two stages, then edge detect
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1   <= 11'h000;
      sync2   <= 11'h000;
      en_last <= 1'b0;
    end else begin
      sync1   <= {reg_select, read_write, enable, bus_in};
      sync2   <= sync1;
      en_last <= s_en;
    end
  end

  wire strobe = en_last && !s_en;  // falling edge of enable

  // full byte assembled from one or two strobes
  // nibble pairing, high first
  wire       byte_ok  = bus_width || nib_hi_done;
  wire [7:0] byte_val = bus_width ? s_dat : {nib_hold, s_dat[7:4]};
  wire [7:0] rd_byte  = sel_glyph ? glyph_mem[addr_counter[5:0]] :
                        disp_mem[disp_index(addr_counter)];
  // status word, busy on top bit
  wire [7:0] status   = {busy_flag, addr_counter};

  // main decode: instructions, data, busy timing
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_counter <= 7'h00;
      dir_inc      <= 1'b1;
      auto_scroll  <= 1'b0;
      display_on   <= 1'b0;
      cursor_on    <= 1'b0;
      blink_on     <= 1'b0;
      bus_width    <= `RST_BUS_WIDTH;
      two_line     <= `RST_LINES;
      font_tall    <= 1'b0;
      sel_glyph    <= 1'b0;
      shift_offset <= 7'h00;
      nib_hi_done  <= 1'b0;
      nib_hold     <= 4'h0;
      busy_count   <= 13'h0000;
      busy_flag    <= 1'b0;
      clearing     <= 1'b0;
      clr_idx      <= 7'h00;
      bus_out      <= 8'h00;
      bus_oe       <= 1'b0;
      buf_push     <= 1'b0;
      buf_word     <= 8'h00;
    end else begin
      buf_push <= 1'b0;
      if (tick && busy_count != 13'h0000)
        busy_count <= busy_count - 13'h0001;
      busy_flag <= (busy_count != 13'h0000) || clearing;
      if (clearing) begin
        disp_mem[clr_idx] <= `SPACE_CODE;
        clr_idx           <= clr_idx + 7'h01;
        if (clr_idx == CLR_END[6:0])
          clearing <= 1'b0;
      end
      // drive pins while enable high on a read
      bus_oe <= s_en && s_rw;
      if (s_en && s_rw && !en_last) begin
        // present selected ram byte or status
        if (bus_width)
          bus_out <= s_rs ? rd_byte : status;
        else
          bus_out <= nib_hi_done ? {(s_rs ? rd_byte[3:0] : status[3:0]), 4'h0}
                                 : (s_rs ? rd_byte : status);
      end
      if (strobe) begin
        if (!bus_width && !nib_hi_done) begin
          nib_hi_done <= 1'b1;
          nib_hold    <= s_dat[7:4];
        end else
          nib_hi_done <= 1'b0;
      end
      if (strobe && byte_ok) begin
        if (s_rs && !s_rw) begin
          if (sel_glyph)
            glyph_mem[addr_counter[5:0]] <= byte_val;
          else
            disp_mem[disp_index(addr_counter)] <= byte_val;
          addr_counter <= step_addr(addr_counter, dir_inc, two_line, sel_glyph);
          if (auto_scroll && !sel_glyph)
            shift_offset <= wrap40(shift_offset, !dir_inc);
          busy_count <= SHORT_T[12:0];
        end else if (s_rs && s_rw) begin
          buf_word     <= rd_byte;
          buf_push     <= buf_in_ready;
          addr_counter <= step_addr(addr_counter, dir_inc, two_line, sel_glyph);
          busy_count   <= SHORT_T[12:0];
        end else if (!s_rs && !s_rw) begin
          busy_count <= SHORT_T[12:0];
          if (byte_val[7]) begin
            addr_counter <= byte_val[6:0];
            sel_glyph    <= 1'b0;
          end else if (byte_val[6]) begin
            addr_counter <= {1'b0, byte_val[5:0]};
            sel_glyph    <= 1'b1;
          end else if (byte_val[5]) begin
            bus_width <= byte_val[4];
            two_line  <= byte_val[3];
            font_tall <= byte_val[2];
          end else if (byte_val[4]) begin
            if (!byte_val[3]) begin
              addr_counter <= step_disp(addr_counter, byte_val[2], two_line);
            end else begin
              shift_offset <= wrap40(shift_offset, byte_val[2]);
            end
          end else if (byte_val[3]) begin
            display_on <= byte_val[2];
            cursor_on  <= byte_val[1];
            blink_on   <= byte_val[0];
          end else if (byte_val[2]) begin
            dir_inc     <= byte_val[1];
            auto_scroll <= byte_val[0];
          end else if (byte_val[1]) begin
            addr_counter <= 7'h00;
            shift_offset <= 7'h00;
            sel_glyph    <= 1'b0;
            busy_count   <= LONG_T[12:0];
          end else if (byte_val[0]) begin
            addr_counter <= 7'h00;
            shift_offset <= 7'h00;
            dir_inc      <= 1'b1;
            sel_glyph    <= 1'b0;
            clearing     <= 1'b1;
            clr_idx      <= 7'h00;
            busy_count   <= LONG_T[12:0];
          end
        end
        // status read takes no execution time
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blink_div   <= 9'h000;
      blink_phase <= 1'b0;
    end else if (!blink_on) begin
      blink_div   <= 9'h000;
      blink_phase <= 1'b0;
    end else if (tick) begin
      blink_div <= blink_div + 9'h001;
      if (blink_div == 9'h1ff)
        blink_phase <= ~blink_phase;
    end
  end

  // cursor cell as the panel sees it; off display shows nothing
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      cursor_cell <= `SPACE_CODE;
    else if (!display_on)
      cursor_cell <= `SPACE_CODE;
    else if (blink_phase)
      cursor_cell <= `ONES_CODE;
    else
      cursor_cell <= disp_mem[disp_index(addr_counter)];
  end

  // output stage reloads when empty or taken, so a stall holds its word
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (buf_pop) begin
      rd_data  <= buf_out_data;
      rd_valid <= buf_out_valid;
    end
  end

endmodule // lcd_ctl

// *** bench/lcd_ctl_checker.sv ***
/* port assertions for the display controller.
   assumes one clock, async active-low reset, bound to lcd_ctl. */
`timescale 1ns/1ps
`include "lcd_ctl_defines.vh"
module lcd_ctl_checker (
  input wire       clock,
  input wire       nrst,
  input wire       reg_select,
  input wire       read_write,
  input wire       enable,
  input wire       bus_oe,
  input wire       busy_flag,
  input wire [6:0] addr_counter,
  input wire       display_on,
  input wire       blink_on,
  input wire       bus_width,
  input wire       two_line,
  input wire       font_tall,
  input wire [6:0] shift_offset,
  input wire       blink_phase,
  input wire [7:0] cursor_cell,
  input wire       rd_ready,
  input wire [7:0] rd_data,
  input wire       rd_valid
);
  // loose busy bounds: one tick slack for divider phase
  localparam int SMIN = (`T_SHORT_TICKS - 1) * `OSC_DIV;
  localparam int LMAX = (`T_LONG_TICKS + 1) * `OSC_DIV + `DISP_DEPTH + 20;
  int bcnt;  // length of the current busy run
  // busy run counter
  always @(posedge clock or negedge nrst) begin
    if (!nrst) bcnt <= 0;
    else bcnt <= busy_flag ? bcnt + 1 : 0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // full-width write strobe ending
  sequence s_wr_fall;
    enable && !read_write && bus_width ##1 !enable;
  endsequence
  AST_BUSY_RISE: assert property (s_wr_fall |-> ##[2:6] busy_flag)
    else $error("busy did not follow an instruction");
  AST_BUSY_MIN: assert property ($fell(busy_flag) |-> bcnt >= SMIN)
    else $error("busy ended too early");
  AST_BUSY_MAX: assert property (bcnt <= LMAX)
    else $error("busy lasted too long");
  AST_STATUS_NO_BUSY: assert property ($rose(busy_flag) |-> !($past(read_write, 2) && !$past(reg_select, 2)))
    else $error("status read started busy");
  AST_OE_READ: assert property (bus_oe |-> read_write)
    else $error("pins driven outside a read");
  AST_OFFSET_RANGE: assert property (shift_offset < 7'd40)
    else $error("display origin out of range");
  AST_CFG_AT_TAKE: assert property ($changed({bus_width, two_line, font_tall}) |-> !enable && !$past(enable))
    else $error("configuration changed without a strobe");
  AST_LINE_RANGE: assert property (two_line |-> addr_counter <= 7'h67)
    else $error("counter left the two-line map");
  AST_DARK_CELL: assert property (!display_on && !$past(display_on) |-> cursor_cell == 8'h20)
    else $error("cell visible with display off");
  AST_BLINK_STOP: assert property (!blink_on && !$past(blink_on) |-> !blink_phase)
    else $error("blink phase while blink off");
  AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word lost while stalled");
endmodule // lcd_ctl_checker
bind lcd_ctl lcd_ctl_checker lcd_ctl_checker_i (.clock(clock), .nrst(nrst), .reg_select(reg_select),
  .read_write(read_write), .enable(enable), .bus_oe(bus_oe), .busy_flag(busy_flag),
  .addr_counter(addr_counter), .display_on(display_on), .blink_on(blink_on), .bus_width(bus_width),
  .two_line(two_line), .font_tall(font_tall), .shift_offset(shift_offset), .blink_phase(blink_phase),
  .cursor_cell(cursor_cell), .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid));

// *** bench/lcd_host.sv ***
/* host model on the parallel bus: strobes, nibble pairs, busy polling.
   assumes the controller samples pins through a synchroniser. */
`timescale 1ns/1ps
module lcd_host (
  input  wire       clock,
  input  wire [7:0] bus_out,
  input  wire       bus_oe,
  output reg        reg_select,
  output reg        read_write,
  output reg        enable,
  output wire [7:0] bus_in,
  output reg        hung
);
  reg [7:0] drv;  // last byte driven
  reg       nib;  // four-bit transfers
  integer   n;    // poll count
  // released lines show the inverse, never a stale value
  assign bus_in = bus_oe ? bus_out : (read_write ? ~drv : drv);
  initial begin
    reg_select = 1'b0;
    read_write = 1'b0;
    enable = 1'b0;
    drv = 8'h00;
    nib = 1'b0;
    hung = 1'b0;
  end
  // one strobe; pins held after the fall for the synchroniser
  task strobe(input rs, input rw, input [7:0] v, output [7:0] s);
    begin
      @(posedge clock);
      #1 reg_select = rs;
      read_write = rw;
      drv = v;
      @(posedge clock);
      #1 enable = 1'b1;
      repeat (8) @(posedge clock);
      #1 s = bus_out;
      enable = 1'b0;
      repeat (5) @(posedge clock);
      #1 read_write = 1'b0;
    end
  endtask
  // byte as high then low nibble
  task xfer(input rs, input rw, input [7:0] v, output [7:0] s);
    reg [7:0] h;
    begin
      if (nib) begin
        strobe(rs, rw, v, h);
        strobe(rs, rw, {v[3:0], v[7:4]}, s);
        s = {h[7:4], s[7:4]};
      end else
        strobe(rs, rw, v, s);
    end
  endtask
  task idle;
    reg [7:0] s;
    begin
      s = 8'h80;
      n = 0;
      while (s[7] !== 1'b0 && n < 3000) begin
        xfer(1'b0, 1'b1, 8'h00, s);
        n = n + 1;
      end
      if (n >= 3000) hung = 1'b1;
    end
  endtask
  task op(input rs, input [7:0] v);
    reg [7:0] s;
    begin
      xfer(rs, 1'b0, v, s);
      idle;
    end
  endtask
  task rd(output [7:0] v);
    begin
      xfer(1'b1, 1'b1, 8'h00, v);
      idle;
    end
  endtask
endmodule // lcd_host

// *** bench/char_lcd_instruction_decoder_tb.sv ***
/* self-checking bench for lcd_ctl driven by the host model.
   assumes a 20 mhz clock; long busy runs make the run about 100k cycles. */
`timescale 1ns/1ps
module char_lcd_instruction_decoder_tb;
  reg        clock, nrst, rd_ready;
  wire       reg_select, read_write, enable, bus_oe, busy_flag, hung, rd_valid;
  wire       display_on, cursor_on, blink_on, bus_width, two_line, font_tall, blink_phase;
  wire [7:0] bus_in, bus_out, cursor_cell, rd_data;
  wire [6:0] addr_counter, shift_offset;
  integer    failures, comparisons, seed, j;
  reg  [7:0] q, d;
  reg  [6:0] a;
  reg  [7:0] rq[$];  // words taken from the read buffer
  lcd_ctl lcd_ctl_i (.clock(clock), .nrst(nrst), .reg_select(reg_select), .read_write(read_write),
    .enable(enable), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .busy_flag(busy_flag),
    .addr_counter(addr_counter), .display_on(display_on), .cursor_on(cursor_on), .blink_on(blink_on),
    .bus_width(bus_width), .two_line(two_line), .font_tall(font_tall), .shift_offset(shift_offset),
    .blink_phase(blink_phase), .cursor_cell(cursor_cell), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_valid(rd_valid));
  lcd_host lcd_host_i (.clock(clock), .bus_out(bus_out), .bus_oe(bus_oe), .reg_select(reg_select),
    .read_write(read_write), .enable(enable), .bus_in(bus_in), .hung(hung));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (rd_valid === 1'b1 && rd_ready === 1'b1) rq.push_back(rd_data);
  // next counter in two-line display space
  function [6:0] step(input [6:0] x, input inc);
    if (inc) step = x == 7'h27 ? 7'h40 : x == 7'h67 ? 7'h00 : x + 7'h01;
    else step = x == 7'h40 ? 7'h27 : x == 7'h00 ? 7'h67 : x - 7'h01;
  endfunction
  function [6:0] base(input [1:0] r);
    base = r == 0 ? 7'h00 : r == 1 ? 7'h40 : r == 2 ? 7'h14 : 7'h54;
  endfunction
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task pull(input [7:0] e);
    begin
      check("rd_count", rq.size() > 0, 8'h01);
      if (rq.size() > 0) check("rd_data", rq.pop_front(), e);
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge hung) begin
    failures = failures + 1;
    close_out;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    seed = 32'h8ce990d9;
    rd_ready = 1'b1;
    nrst = 1'b0;
    repeat (8) @(posedge clock);
    #1 nrst = 1'b1;
    check("cfg", {bus_width, two_line}, 8'h03);
    lcd_host_i.op(0, 8'h34);
    check("cfg", {bus_width, two_line, font_tall}, 8'h05);
    lcd_host_i.op(0, 8'h38);
    check("cfg", {bus_width, two_line, font_tall}, 8'h06);
    for (j = 0; j < 4; j = j + 1) begin
      d = j == 0 ? 8'h07 : $random(seed) & 8'h07;
      lcd_host_i.op(0, 8'h08 | d);
      check("ctl", {display_on, cursor_on, blink_on}, d);
    end
    $display("test function and control done");
    // random cells in the first three rows, plus the first-line end
    for (j = 0; j < 4; j = j + 1) begin
      a = j == 3 ? 7'h27 : base(j) + 7'(($random(seed) & 32'h7fffffff) % 20);
      d = $random(seed);
      lcd_host_i.op(0, {1'b1, a});
      check("counter", addr_counter, a);
      lcd_host_i.op(1, d);
      check("counter", addr_counter, step(a, 1'b1));
      lcd_host_i.op(0, {1'b1, a});
      lcd_host_i.rd(q);
      check("bus", q, d);
      pull(d);
    end
    lcd_host_i.op(0, 8'h04);
    lcd_host_i.op(0, 8'h80);
    lcd_host_i.op(1, 8'h5a);
    check("counter", addr_counter, 8'h67);
    $display("test rows done");
    lcd_host_i.op(0, 8'h85);
    lcd_host_i.op(0, 8'h10);
    check("counter", addr_counter, 8'h04);
    lcd_host_i.op(0, 8'h14);
    check("counter", addr_counter, 8'h05);
    lcd_host_i.op(0, 8'h18);
    check("counter", addr_counter, 8'h05);
    check("shifted", shift_offset != 7'h00, 8'h01);
    lcd_host_i.op(0, 8'h02);
    check("home_origin", shift_offset, 8'h00);
    check("home_counter", addr_counter, 8'h00);
    lcd_host_i.op(0, 8'h80);
    lcd_host_i.rd(q);
    check("kept", q, 8'h5a);
    pull(8'h5a);
    $display("test shift and home done");
    lcd_host_i.op(0, 8'h05);
    lcd_host_i.op(0, 8'h90);
    lcd_host_i.op(1, 8'h3c);
    check("counter", addr_counter, 8'h0f);
    check("scrolled", shift_offset != 7'h00, 8'h01);
    a = shift_offset;
    lcd_host_i.rd(q);
    check("offset", shift_offset, a);
    rq.delete();
    lcd_host_i.op(0, 8'h01);
    check("clear_origin", shift_offset, 8'h00);
    check("clear_counter", addr_counter, 8'h00);
    lcd_host_i.op(1, 8'hc3);
    check("counter", addr_counter, 8'h01);
    lcd_host_i.op(0, 8'h90);
    lcd_host_i.rd(q);
    check("space", q, 8'h20);
    pull(8'h20);
    $display("test scroll and clear done");
    d = $random(seed);
    lcd_host_i.op(0, 8'h7f);
    check("counter", addr_counter, 8'h3f);
    lcd_host_i.op(1, d);
    check("counter", addr_counter, 8'h00);
    lcd_host_i.op(0, 8'h7f);
    lcd_host_i.rd(q);
    check("glyph", q, d);
    pull(d);
    // stalled reader: output stage and two buffer words kept, the fourth dropped
    @(posedge clock);
    #1 rd_ready = 1'b0;
    lcd_host_i.op(0, 8'h80);
    for (j = 0; j < 4; j = j + 1) lcd_host_i.rd(q);
    @(posedge clock);
    #1 rd_ready = 1'b1;
    repeat (6) @(posedge clock);
    pull(8'hc3);
    pull(8'h20);
    pull(8'h20);
    check("left", rq.size(), 8'h00);
    $display("test glyph and buffer done");
    d = $random(seed);
    // width switch: the poll after it already uses the new width
    lcd_host_i.xfer(0, 0, 8'h28, q);
    lcd_host_i.nib = 1'b1;
    lcd_host_i.idle;
    check("width", bus_width, 8'h00);
    lcd_host_i.op(0, 8'h85);
    check("counter", addr_counter, 8'h05);
    lcd_host_i.op(1, d);
    lcd_host_i.op(0, 8'h85);
    lcd_host_i.rd(q);
    check("nibbles", q, d);
    pull(d);
    lcd_host_i.xfer(0, 0, 8'h38, q);
    lcd_host_i.nib = 1'b0;
    lcd_host_i.idle;
    check("width", bus_width, 8'h01);
    $display("test four-bit done");
    close_out;
  end
endmodule // char_lcd_instruction_decoder_tb
